/* hw/bridge_spi_cfg.svh */
/*
 * constants of the bridge driver serial link: word layout, status
 * addresses, link timing and the controller's register offsets.
 * assumes a 100 MHz system clock on both ends.
 */
`ifndef BRIDGE_SPI_CFG_SVH
`define BRIDGE_SPI_CFG_SVH

// ==========================================================
// word layout
`define WORD_W 16
`define BYTE_BITS 8
`define CTRL_CLR_BIT 15
`define CTRL_ADDR_HI 14
`define CTRL_ADDR_LO 13
`define CTRL_OLSD_BIT 12
`define DIAG_SUPPLY_BIT 15
`define DIAG_TEMP_BIT 14
`define STAT_SHORT 2'h0
`define STAT_LOAD 2'h1
`define STAT_BRIDGE 2'h2
`define ADDR_RESET 2'h0

// ==========================================================
// link timing
`define CLK_NS 10
`define SCLK_HALF_NS 80
`define SCLK_HALF_CYC (`SCLK_HALF_NS / `CLK_NS)

// ==========================================================
// controller registers
`define REG_TX 2'h0
`define REG_RX 2'h1
`define REG_STATUS 2'h2

`endif

/* hw/spi_types_pkg.sv */
/*
 * types shared by both ends of the bridge driver link.
 * assumes bridge_spi_cfg.svh for the widths.
 */
`include "bridge_spi_cfg.svh"
package spi_types_pkg;
	typedef logic [`WORD_W-1:0] word_t;
	// codes change one bit per step along the frame path, except high to trail and gap to idle
	typedef enum logic [2:0] {
		st_idle = 3'h0,
		st_lead = 3'h1,
		st_high = 3'h3,
		st_low = 3'h2,
		st_trail = 3'h6,
		st_gap = 3'h7
	} link_state_t;
endpackage

/* hw/spi_link_if.sv */
/*
 * the four-wire serial link between controller and bridge driver.
 * assumes one device; the bench has no further chained devices.
 */
`timescale 1ns/1ns
interface spi_link_if;
	logic sclk;
	logic chip_select_n;
	logic sdi;
	logic sdo;
	logic sdo_oe;
	logic miso;
	// released data-out wire reads as its pull-up level
	assign miso = sdo_oe ? sdo : 1'b1;
	modport device (
		input sclk,
		input chip_select_n,
		input sdi,
		output sdo,
		output sdo_oe
	);
	modport host (
		output sclk,
		output chip_select_n,
		output sdi,
		input miso
	);
endinterface

/* hw/bridge_spi_device.sv */
/*
 * serial slave of the half-bridge driver: control word in, diagnosis
 * word out, two-frame status read and deferred status clear.
 * assumes hclk far faster than the link clock (at least 8x).
 */
// Functional notes
// - master opens frame with select falling
// - both sides sample data on falling clock
// - clock low whenever select changes
// - words travel most significant bit first
// - select rising loads and executes control word
// - data out released when select high
// - shift register passes bits for chaining
// - control word holds until replaced or reset
// - select falling captures live diagnosis word
// - accept only multiples of eight bits
// - status read returns in following frame
// - status address defaults to zero
// - status clear acts after next frame
// - address plus clear bit form one command
// - bridge status shows real stage state
// - first diagnosis word: only supply, temperature
// - both words are sixteen bits
// - latched faults hold until clear or reset
// - inhibit low resets banks, stages off
// - power-on reset erases data, outputs off
`timescale 1ns/1ns
`include "bridge_spi_cfg.svh"
module bridge_spi_device
	import spi_types_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	spi_link_if.device link,
	input wire logic inhibit_pin,
	input wire logic supply_fail_flag,
	input wire logic temp_warning_flag,
	input wire logic [5:0] overcurrent_flag,
	input wire logic [5:0] open_load_flag,
	input wire logic [11:0] half_bridge_state,
	output logic [`WORD_W-1:0] control_word,
	output logic [5:0] stage_enable
);

	// ==========================================================
	// synchronisers
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic inhibit_meta;
	logic inhibit_sync;
	logic sclk_d;
	logic sel_d;

	// pins cross into hclk through two flops each
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1 <= 3'h2;
			sync2 <= 3'h2;
			inhibit_meta <= 1'b0;
			inhibit_sync <= 1'b0;
			sclk_d <= 1'b0;
			sel_d <= 1'b1;
		end else begin
			sync1 <= {link.sclk, link.chip_select_n, link.sdi};
			sync2 <= sync1;
			inhibit_meta <= inhibit_pin;
			inhibit_sync <= inhibit_meta;
			sclk_d <= sync2[2];
			sel_d <= sync2[1];
		end
	end

	logic sclk_s;
	logic sel_s;
	logic sdi_s;
	logic sclk_fall;
	logic sclk_rise;
	logic cs_fall;
	logic cs_rise;

	// edges of the link clock and select, found in hclk
	assign sclk_s = sync2[2];
	assign sel_s = sync2[1];
	assign sdi_s = sync2[0];
	assign sclk_fall = sclk_d & ~sclk_s;
	assign sclk_rise = ~sclk_d & sclk_s;
	assign cs_fall = sel_d & ~sel_s;
	assign cs_rise = ~sel_d & sel_s;

	// ==========================================================
	// diagnosis word
	logic [5:0] short_lat;
	logic [5:0] load_lat;
	logic [1:0] addr_sel;
	logic first_diag;

	// build the word for one status address
	function automatic word_t diag_word(input logic [1:0] a,
			input logic first);
		logic [11:0] data;
		data = 12'h000;
		unique case (a)
			`STAT_SHORT: data = {6'h00, short_lat};
			`STAT_LOAD: data = {6'h00, load_lat};
			`STAT_BRIDGE: data = half_bridge_state;
			default: data = 12'h000;
		endcase
		// only live supply and temperature in the first word
		if (first) begin
			diag_word = {supply_fail_flag, temp_warning_flag,
				14'h0000};
		end else begin
			diag_word = {supply_fail_flag, temp_warning_flag, a, data};
		end
	endfunction

	// ==========================================================
	// frame shifter
	word_t shift;
	logic [2:0] bit_cnt;
	logic got_bits;
	logic sdo_q;
	logic oe_q;
	word_t next_shift;
	logic [2:0] next_bit_cnt;
	logic next_got_bits;
	logic next_sdo_q;
	logic next_oe_q;
	logic next_first_diag;
	logic frame_ok;

	// only whole bytes count as a command
	assign frame_ok = cs_rise & got_bits
		& (bit_cnt == 3'h0);

	// shift on falling clock, drive out on rising clock
	always_comb begin
		next_shift = shift;
		next_bit_cnt = bit_cnt;
		next_got_bits = got_bits;
		next_sdo_q = sdo_q;
		next_oe_q = oe_q;
		next_first_diag = first_diag;
		if (cs_fall) begin
			next_shift = diag_word(addr_sel, first_diag);
			next_sdo_q = next_shift[`WORD_W-1];
			next_bit_cnt = 3'h0;
			next_got_bits = 1'b0;
			next_oe_q = 1'b1;
			next_first_diag = 1'b0;
		end else if (cs_rise) begin
			next_oe_q = 1'b0;
		end else if (!sel_s) begin
			if (sclk_fall) begin
				// msb leaves first, new bit enters at lsb
				next_shift = {shift[`WORD_W-2:0], sdi_s};
				next_bit_cnt = bit_cnt + 3'h1;
				next_got_bits = 1'b1;
			end
			if (sclk_rise) begin
				next_sdo_q = shift[`WORD_W-1];
			end
		end
		if (!inhibit_sync) begin
			next_first_diag = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shift <= 16'h0000;
			bit_cnt <= 3'h0;
			got_bits <= 1'b0;
			sdo_q <= 1'b0;
			oe_q <= 1'b0;
			first_diag <= 1'b1;
		end else begin
			shift <= next_shift;
			bit_cnt <= next_bit_cnt;
			got_bits <= next_got_bits;
			sdo_q <= next_sdo_q;
			oe_q <= next_oe_q;
			first_diag <= next_first_diag;
		end
	end

	assign link.sdo = sdo_q;
	assign link.sdo_oe = oe_q;

	// ==========================================================
	// register bank
	word_t ctrl;
	logic clr_pend;
	logic [1:0] clr_addr;
	word_t next_ctrl;
	logic [1:0] next_addr_sel;
	logic next_clr_pend;
	logic [1:0] next_clr_addr;
	logic [5:0] next_short_lat;
	logic [5:0] next_load_lat;
	logic [5:0] next_stage_enable;

	// command taken at select rising; a clear set up by the previous
	// frame runs now, so the master saw the data before it vanished
	always_comb begin
		next_ctrl = ctrl;
		next_addr_sel = addr_sel;
		next_clr_pend = clr_pend;
		next_clr_addr = clr_addr;
		next_short_lat = short_lat;
		next_load_lat = load_lat;
		if (frame_ok) begin
			next_ctrl = shift;
			next_addr_sel = shift[`CTRL_ADDR_HI:`CTRL_ADDR_LO];
			next_clr_pend = shift[`CTRL_CLR_BIT];
			next_clr_addr = shift[`CTRL_ADDR_HI:`CTRL_ADDR_LO];
			if (clr_pend && clr_addr == `STAT_SHORT) begin
				next_short_lat = 6'h00;
			end
			if (clr_pend && clr_addr == `STAT_LOAD) begin
				next_load_lat = 6'h00;
			end
		end
		// a fault in the clearing cycle is kept: set wins
		next_short_lat = next_short_lat | overcurrent_flag;
		next_load_lat = next_load_lat | open_load_flag;
		next_stage_enable = ~(next_short_lat
			| (next_load_lat & {6{next_ctrl[`CTRL_OLSD_BIT]}}));
		if (!inhibit_sync) begin
			next_ctrl = 16'h0000;
			next_addr_sel = `ADDR_RESET;
			next_clr_pend = 1'b0;
			next_clr_addr = `ADDR_RESET;
			next_short_lat = 6'h00;
			next_load_lat = 6'h00;
			next_stage_enable = 6'h00;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= 16'h0000;
			addr_sel <= `ADDR_RESET;
			clr_pend <= 1'b0;
			clr_addr <= `ADDR_RESET;
			short_lat <= 6'h00;
			load_lat <= 6'h00;
			stage_enable <= 6'h00;
		end else begin
			ctrl <= next_ctrl;
			addr_sel <= next_addr_sel;
			clr_pend <= next_clr_pend;
			clr_addr <= next_clr_addr;
			short_lat <= next_short_lat;
			load_lat <= next_load_lat;
			stage_enable <= next_stage_enable;
		end
	end

	assign control_word = ctrl;

endmodule

/* hw/bridge_spi_host.sv */
/*
 * link master for the bridge driver, ordered by software over
 * AHB-Lite. assumes a single slave bus and a zero-wait answer.
 */
`timescale 1ns/1ns
`include "bridge_spi_cfg.svh"
module bridge_spi_host
	import spi_types_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	spi_link_if.host link
);

	// ==========================================================
	// bus slave
	logic dph_wr;
	logic [1:0] dph_reg;
	word_t tx_data;
	word_t rx_data;
	logic done;
	link_state_t state;
	logic ap_take;
	logic start;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// hsize is ignored: only whole words are used
	assign ap_take = hsel & htrans[1] & hready;
	// a write while a frame runs is dropped
	assign start = dph_wr && dph_reg == `REG_TX && state == st_idle;

	// address phase latched; read data set up for the next cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_wr <= 1'b0;
			dph_reg <= 2'h0;
			hrdata <= 32'h0000_0000;
		end else begin
			dph_wr <= ap_take & hwrite;
			dph_reg <= haddr[3:2];
			if (ap_take && !hwrite) begin
				unique case (haddr[3:2])
					`REG_TX: hrdata <= {16'h0000, tx_data};
					`REG_RX: hrdata <= {16'h0000, rx_data};
					`REG_STATUS: hrdata <= {30'h0000_0000, done,
						state != st_idle};
					default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================================
	// frame sequencer
	logic miso1;
	logic miso2;
	logic [3:0] div;
	logic [4:0] bits;
	word_t shift;
	logic sclk_q;
	logic select_q;
	logic sdi_q;
	link_state_t next_state;
	logic [3:0] next_div;
	logic [4:0] next_bits;
	word_t next_shift;
	word_t next_tx_data;
	word_t next_rx_data;
	logic next_done;
	logic next_sclk_q;
	logic next_select_q;
	logic next_sdi_q;
	logic half_up;

	assign half_up = div == 4'(`SCLK_HALF_CYC - 1);

	// clock stays low around every select change
	always_comb begin
		next_state = state;
		next_div = half_up ? 4'h0 : div + 4'h1;
		next_bits = bits;
		next_shift = shift;
		next_tx_data = tx_data;
		next_rx_data = rx_data;
		next_done = done;
		next_sclk_q = sclk_q;
		next_select_q = select_q;
		next_sdi_q = sdi_q;
		unique case (state)
			st_idle: begin
				next_div = 4'h0;
				if (start) begin
					next_tx_data = hwdata[`WORD_W-1:0];
					next_shift = hwdata[`WORD_W-1:0];
					next_sdi_q = hwdata[`WORD_W-1];
					next_select_q = 1'b0;
					next_bits = 5'h00;
					next_done = 1'b0;
					next_state = st_lead;
				end
			end
			st_lead, st_low: if (half_up) begin
				next_sclk_q = 1'b1;
				next_sdi_q = shift[`WORD_W-1];
				next_state = st_high;
			end
			st_high: if (half_up) begin
				// sample the device on the falling clock
				next_sclk_q = 1'b0;
				next_shift = {shift[`WORD_W-2:0], miso2};
				next_bits = bits + 5'h01;
				next_state = (bits == 5'(`WORD_W - 1)) ? st_trail
					: st_low;
			end
			st_trail: if (half_up) begin
				next_select_q = 1'b1;
				next_rx_data = shift;
				next_done = 1'b1;
				next_state = st_gap;
			end
			st_gap: if (half_up) begin
				next_state = st_idle;
			end
			default: next_state = st_idle;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			miso1 <= 1'b0;
			miso2 <= 1'b0;
			state <= st_idle;
			div <= 4'h0;
			bits <= 5'h00;
			shift <= 16'h0000;
			tx_data <= 16'h0000;
			rx_data <= 16'h0000;
			done <= 1'b0;
			sclk_q <= 1'b0;
			select_q <= 1'b1;
			sdi_q <= 1'b0;
		end else begin
			miso1 <= link.miso;
			miso2 <= miso1;
			state <= next_state;
			div <= next_div;
			bits <= next_bits;
			shift <= next_shift;
			tx_data <= next_tx_data;
			rx_data <= next_rx_data;
			done <= next_done;
			sclk_q <= next_sclk_q;
			select_q <= next_select_q;
			sdi_q <= next_sdi_q;
		end
	end

	assign link.sclk = sclk_q;
	assign link.chip_select_n = select_q;
	assign link.sdi = sdi_q;

endmodule

/* verification/bridge_spi_sva.sv */
/*
 * link checker: timing relations between the serial link wires.
 * assumes it sits beside spi_link_if, clocked by the system clock.
 */
`timescale 1ns/1ns
module bridge_spi_sva (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic sclk,
	input wire logic chip_select_n,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe
);
	logic sclk_q;
	logic [4:0] edges;
	logic [4:0] next_edges;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ==========================================================
	// rising link clock edges seen in the current frame
	always_comb begin
		next_edges = chip_select_n ? 5'h00 : edges + {4'h0, sclk & !sclk_q};
	end
	// cleared while deselected, so a short frame cannot hide in the count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			edges <= 5'h00;
			sclk_q <= 1'h0;
		end else begin
			edges <= next_edges;
			sclk_q <= sclk;
		end
	end
	// ==========================================================
	// link relations
	AST_SEL_CLK_LOW: assert property ($changed(chip_select_n) |->
		!sclk && !$past(sclk)) else $error("clock high at select change");
	AST_IDLE_CLK_LOW: assert property (chip_select_n |-> !sclk)
		else $error("clock runs outside frame");
	AST_LEAD_TIME: assert property ($fell(chip_select_n) |->
		!sclk [*8] ##1 sclk) else $error("lead time wrong");
	AST_CLK_HIGH: assert property ($rose(sclk) |->
		sclk [*8] ##1 !sclk) else $error("clock high time wrong");
	AST_SDI_STABLE: assert property ($fell(sclk) |-> $stable(sdi))
		else $error("data in moves at sample edge");
	AST_SDO_STABLE: assert property ($fell(sclk) |->
		$stable(sdo) && sdo_oe) else $error("data out moves at sample");
	AST_SDO_RELEASE: assert property (chip_select_n [*6] |-> !sdo_oe)
		else $error("data out driven while deselected");
	AST_SDO_DRIVE: assert property ($fell(chip_select_n) |->
		##[1:6] sdo_oe) else $error("data out not driven in frame");
	AST_WORD_BITS: assert property ($rose(chip_select_n) |->
		edges == 5'h10) else $error("frame is not sixteen bits");
	// main scenarios
	cover property ($rose(chip_select_n) && edges == 5'h10);
	cover property ($fell(sclk) && sdo);
	cover property (chip_select_n [*6] ##1 !chip_select_n);
endmodule

/* verification/test_bridge_driver_spi_slave.sv */
/*
 * bench: software orders frames over AHB-Lite, device flags are driven.
 * assumes hreadyout is the bus ready and one slave on the bus.
 */
`timescale 1ns/1ns
module test_bridge_driver_spi_slave
	import spi_types_pkg::*;
;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic inhibit_pin, supply_fail_flag, temp_warning_flag;
	logic [5:0] overcurrent_flag, open_load_flag, stage_enable;
	logic [11:0] half_bridge_state;
	word_t control_word;
	int fails, checks_done;
	// ==========================================================
	// structure
	assign hready = hreadyout;
	spi_link_if spi_link_if_inst ();
	bridge_spi_host bridge_spi_host_inst (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
		.hrdata, .link(spi_link_if_inst));
	bridge_spi_device bridge_spi_device_inst (.hclk, .hresetn,
		.link(spi_link_if_inst), .inhibit_pin, .supply_fail_flag,
		.temp_warning_flag, .overcurrent_flag, .open_load_flag,
		.half_bridge_state, .control_word, .stage_enable);
	bridge_spi_sva bridge_spi_sva_inst (.hclk, .hresetn,
		.sclk(spi_link_if_inst.sclk),
		.chip_select_n(spi_link_if_inst.chip_select_n),
		.sdi(spi_link_if_inst.sdi), .sdo(spi_link_if_inst.sdo),
		.sdo_oe(spi_link_if_inst.sdo_oe));
	// 100 MHz system clock
	initial begin
		hclk = 1'h0;
		forever #5 hclk = ~hclk;
	end
	// ==========================================================
	// reporting
	task close_out();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task hung();
		fails++;
		$display("BAD %0t wait ran out", $time);
		close_out();
	endtask
	// ==========================================================
	// bus and frame tasks; the ready wait is bounded, never assumed
	task wait_ready();
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'h1) begin
			n++;
			if (n > 20) hung();
			@(posedge hclk);
		end
	endtask
	task xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
		hsel <= 1'h1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask
	// send one word, wait for done, compare the word received back
	task frame(input word_t w, input word_t exp);
		int n;
		xfer(32'h0000_0000, 1'h1, {16'h0000, w});
		n = 0;
		do begin
			xfer(32'h0000_0008, 1'h0, 32'h0000_0000);
			n++;
			if (n > 200) hung();
		end while (rd[1:0] !== 2'h2);
		xfer(32'h0000_0004, 1'h0, 32'h0000_0000);
		chk(rd[15:0], exp);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		hresetn = 1'h0;
		hsel = 1'h0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		inhibit_pin = 1'h1;
		supply_fail_flag = 1'h1;
		temp_warning_flag = 1'h0;
		overcurrent_flag = 6'h00;
		open_load_flag = 6'h00;
		half_bridge_state = 12'h5a3;
		fails = 0;
		checks_done = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'h1;
		frame(16'h40a5, 16'h8000);
		chk(control_word, 16'h40a5);
		// the transmit register reads back the last word sent
		xfer(32'h0000_0000, 1'h0, 32'h0000_0000);
		chk(rd[15:0], 16'h40a5);
		// writes to the receive and an unmapped offset are ignored
		xfer(32'h0000_0004, 1'h1, 32'h0000_1234);
		xfer(32'h0000_000c, 1'h1, 32'h0000_1234);
		xfer(32'h0000_0004, 1'h0, 32'h0000_0000);
		chk(rd[15:0], 16'h8000);
		chk(control_word, 16'h40a5);
		temp_warning_flag <= 1'h1;
		overcurrent_flag <= 6'h04;
		@(posedge hclk);
		overcurrent_flag <= 6'h00;
		repeat (4) @(posedge hclk);
		chk({10'h000, stage_enable}, 16'h003b);
		frame(16'h8000, 16'he5a3);
		chk({10'h000, stage_enable}, 16'h003b);
		frame(16'h0000, 16'hc004);
		open_load_flag <= 6'h01;
		@(posedge hclk);
		open_load_flag <= 6'h00;
		frame(16'h2000, 16'hc000);
		chk({10'h000, stage_enable}, 16'h003f);
		frame(16'h3000, 16'hd001);
		chk({10'h000, stage_enable}, 16'h003e);
		inhibit_pin <= 1'h0;
		repeat (8) @(posedge hclk);
		chk(control_word, 16'h0000);
		chk({10'h000, stage_enable}, 16'h0000);
		inhibit_pin <= 1'h1;
		repeat (8) @(posedge hclk);
		frame(16'h2000, 16'hc000);
		hresetn <= 1'h0;
		repeat (3) @(posedge hclk);
		chk(control_word, 16'h0000);
		// address 1 was selected before reset; reset must bring back 0
		chk({14'h0000, bridge_spi_device_inst.addr_sel}, 16'h0000);
		hresetn <= 1'h1;
		frame(16'h4000, 16'hc000);
		close_out();
	end
endmodule
